/* hw/uart_status_ctrl.sv */
// Line status, modem status and extra feature control logic
`timescale 1ns/1ps
`default_nettype none
module uart_status_ctrl
  import uart_stat_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [7:0]             RDATA,
  input  wire logic              ENH_UNLOCK,
  input  wire logic              LS_INT_EN,
  input  wire logic              MS_INT_EN,
  input  wire logic              SW_FLOW_ON,
  input  wire logic              RX_CHAR_DONE,
  input  wire rx_err_t           RX_CHAR_ERR,
  input  wire logic              RX_FIFO_FULL,
  input  wire logic              RX_HEAD_VALID,
  input  wire rx_err_t           RX_HEAD_ERR,
  input  wire logic              RX_POP,
  output logic                   RX_PUSH,
  input  wire logic              TX_HOLD_EMPTY,
  input  wire logic              TX_SHIFT_EMPTY,
  input  wire logic              TX_BUSY,
  input  wire logic              TXD,
  input  wire logic              IR_ENC_TX,
  input  wire logic              IR_DEC_RX,
  input  wire logic              RX_PIN,
  input  wire modem_t            MODEM_N,
  output logic                   TX_PIN,
  output logic                   RX_DATA,
  output logic                   IR_DEC_IN,
  output logic                   RTS_N,
  output logic                   IRQ_O,
  output logic                   IRQ_OE,
  output logic                   BRG_TICK,
  output logic                   XON_RESUME
);
  localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);

  logic [7:0]       mcr_q;
  logic [XFR_W-1:0] xfr_q;
  logic [4:0]       s1_q, s2_q, s3_q, pin_q;
  logic             rx_s;
  modem_t           mod_n, dlt_q;
  logic             oe_q, pe_q, fe_q, bi_q, imm_q;
  logic             brk_hold_q, hv_q, pop_q;
  logic [CNT_W-1:0] err_cnt_q;
  logic [1:0]       presc_cnt_q;
  logic             rd_lsr, rd_msr, wr_mcr, wr_xfr;
  logic             head_new, push, head_bad;
  modem_t           chg;
  logic             ls_irq, ms_irq, irq;
  logic [7:0]       lsr_v, msr_v;

  assign rd_lsr = RD && (ADDR == OFF_LSR);
  assign rd_msr = RD && (ADDR == OFF_MSR);
  assign wr_mcr = WR && (ADDR == OFF_MCR);
  assign wr_xfr = WR && (ADDR == OFF_XFR);

  // Control registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mcr_q <= MCR_RST;
    end else if (CE && wr_mcr) begin
      // [R20] Upper bits locked
      if (ENH_UNLOCK) begin
        mcr_q <= WDATA;
      end else begin
        mcr_q <= (mcr_q & MCR_ENH_MASK) | (WDATA & ~MCR_ENH_MASK);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      xfr_q <= XFR_RST;
    end else if (CE && wr_xfr && ENH_UNLOCK) begin
      // [R22] Reserved bits dropped
      xfr_q <= WDATA[XFR_W-1:0];
    end
  end

  // Pin synchronisers, change taken when stages two and three agree
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q  <= PIN_IDLE;
      s2_q  <= PIN_IDLE;
      s3_q  <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end else if (CE) begin
      s1_q <= {MODEM_N, RX_PIN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 5; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign rx_s  = pin_q[0];
  assign mod_n = pin_q[4:1];

  // Modem change detection
  always_comb begin
    chg.cts = (s3_q[1] == s2_q[1]) && (s3_q[1] != mod_n.cts);
    chg.dsr = (s3_q[2] == s2_q[2]) && (s3_q[2] != mod_n.dsr);
    // [R19] Ring end edge only
    chg.ri  = (s3_q[3] == s2_q[3]) && s3_q[3] && !mod_n.ri;
    chg.cd  = (s3_q[4] == s2_q[4]) && (s3_q[4] != mod_n.cd);
  end

  // [R18] Change flags set
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dlt_q <= '0;
    end else if (CE) begin
      // [R21] Clear on read
      dlt_q <= chg | (dlt_q & ~{4{rd_msr}});
    end
  end

  // Read-position tracking for the receive FIFO head
  assign head_new = RX_HEAD_VALID && (!hv_q || pop_q);
  assign head_bad = |RX_HEAD_ERR;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hv_q  <= 1'b0;
      pop_q <= 1'b0;
    end else if (CE) begin
      hv_q  <= RX_HEAD_VALID;
      pop_q <= RX_POP;
    end
  end

  // [R8] One break character per low period
  assign push = RX_CHAR_DONE && !RX_FIFO_FULL &&
                !(RX_CHAR_ERR.brk && brk_hold_q);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      brk_hold_q <= 1'b0;
    end else if (CE) begin
      if (push && RX_CHAR_ERR.brk) begin
        brk_hold_q <= 1'b1;
      end else if (rx_s) begin
        brk_hold_q <= 1'b0;
      end
    end
  end

  // [R5] Overrun on full FIFO
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      oe_q <= 1'b0;
    end else if (CE) begin
      oe_q <= (RX_CHAR_DONE && RX_FIFO_FULL) || (oe_q && !rd_lsr);
    end
  end

  // [R6] Parity of head character
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pe_q <= 1'b0;
    end else if (CE) begin
      pe_q <= (head_new && RX_HEAD_ERR.perr) || (pe_q && !rd_lsr);
    end
  end

  // [R7] Framing of head character
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fe_q <= 1'b0;
    end else if (CE) begin
      fe_q <= (head_new && RX_HEAD_ERR.ferr) || (fe_q && !rd_lsr);
    end
  end

  // [R8] Break flag cleared by read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bi_q <= 1'b0;
    end else if (CE) begin
      bi_q <= (head_new && RX_HEAD_ERR.brk) || (bi_q && !rd_lsr);
    end
  end

  // [R9] Immediate bad-character report
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      imm_q <= 1'b0;
    end else if (CE) begin
      imm_q <= (xfr_q[XFR_LSIMM] && push && (|RX_CHAR_ERR)) ||
               (imm_q && !rd_lsr);
    end
  end

  // [R12] Count of flagged characters held
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      err_cnt_q <= '0;
    end else if (CE) begin
      case ({push && (|RX_CHAR_ERR), RX_POP && RX_HEAD_VALID && head_bad})
        2'b10:   err_cnt_q <= err_cnt_q + 1'b1;
        2'b01:   err_cnt_q <= err_cnt_q - 1'b1;
        default: err_cnt_q <= err_cnt_q;
      endcase
    end
  end

  // [R4] [R10] [R11] Live status bits
  assign lsr_v = {err_cnt_q != '0, TX_HOLD_EMPTY && TX_SHIFT_EMPTY,
                  TX_HOLD_EMPTY, bi_q, fe_q, pe_q, oe_q, RX_HEAD_VALID};
  assign msr_v = {~mod_n, dlt_q};

  // Register read port
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      if (rd_lsr) begin
        RDATA <= lsr_v;
      end else if (rd_msr) begin
        RDATA <= msr_v;
      end else if (RD && (ADDR == OFF_MCR)) begin
        RDATA <= mcr_q;
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  assign ls_irq = LS_INT_EN && (oe_q || pe_q || fe_q || bi_q || imm_q);
  assign ms_irq = MS_INT_EN && (|dlt_q);
  assign irq    = ls_irq || ms_irq;

  // [R1] Interrupt pin mode
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_O  <= 1'b0;
      IRQ_OE <= 1'b1;
    end else if (CE) begin
      IRQ_O  <= mcr_q[MCR_INTOS] ? 1'b1 : irq;
      IRQ_OE <= mcr_q[MCR_INTOS] ? irq : 1'b1;
    end
  end

  // [R2] [R13] [R14] Serial and infrared routing
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TX_PIN    <= 1'b1;
      RX_DATA   <= 1'b1;
      IR_DEC_IN <= 1'b0;
    end else if (CE) begin
      TX_PIN <= mcr_q[MCR_IR] ? IR_ENC_TX : TXD;
      if (xfr_q[XFR_HDX] && TX_BUSY) begin
        IR_DEC_IN <= 1'b0;
      end else begin
        IR_DEC_IN <= rx_s ^ xfr_q[XFR_IRINV];
      end
      if (!mcr_q[MCR_IR]) begin
        RX_DATA <= rx_s;
      end else if (xfr_q[XFR_HDX] && TX_BUSY) begin
        RX_DATA <= 1'b1;
      end else begin
        RX_DATA <= IR_DEC_RX;
      end
    end
  end

  // [R15] [R16] Direction control on RTS
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RTS_N <= 1'b1;
    end else if (CE) begin
      RTS_N <= xfr_q[XFR_485] ? (TX_BUSY ^ xfr_q[XFR_485INV])
                              : !mcr_q[MCR_RTS];
    end
  end

  // [R3] Baud generator clock enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      presc_cnt_q <= 2'h0;
      BRG_TICK    <= 1'b0;
    end else if (CE) begin
      presc_cnt_q <= presc_cnt_q + 2'h1;
      BRG_TICK    <= !mcr_q[MCR_PRESC] || (presc_cnt_q == PRESC_LAST);
    end
  end

  // [R17] Any character resumes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      XON_RESUME <= 1'b0;
      RX_PUSH    <= 1'b0;
    end else if (CE) begin
      XON_RESUME <= SW_FLOW_ON && xfr_q[XFR_XANY] && RX_CHAR_DONE;
      RX_PUSH    <= push;
    end else begin
      XON_RESUME <= 1'b0;
      RX_PUSH    <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_ls_read;
    CE && rd_lsr && !RX_CHAR_DONE && !head_new;
  endsequence

  // Tick taken in divide mode, so the counter restarted behind it
  sequence s_presc_tick;
    CE && mcr_q[MCR_PRESC] && !wr_mcr ##1
      BRG_TICK && CE && mcr_q[MCR_PRESC] && !wr_mcr;
  endsequence

  a_overrun_set: assert property ( // R5
    CE && RX_CHAR_DONE && RX_FIFO_FULL |=> oe_q && !RX_PUSH)
    else $error("overrun not flagged");

  a_lsr_read_clear: assert property ( // R21
    s_ls_read |=> !oe_q && !pe_q && !fe_q && !bi_q && !imm_q)
    else $error("line status read did not clear");

  a_ring_edge_only: assert property ( // R19
    !dlt_q.ri ##1 dlt_q.ri |-> mod_n.ri && !$past(mod_n.ri))
    else $error("ring flag set without rising edge");

  a_rs485_dir: assert property ( // R16
    CE && xfr_q[XFR_485] && !xfr_q[XFR_485INV] && TX_BUSY |=> RTS_N)
    else $error("direction output wrong while sending");

  a_thre_read: assert property ( // R10
    CE && rd_lsr |=> RDATA[LSR_THRE] == $past(TX_HOLD_EMPTY))
    else $error("holding empty bit mismatch");

  a_unlock_guard: assert property ( // R20
    CE && wr_xfr && !ENH_UNLOCK |=> $stable(xfr_q))
    else $error("feature bits changed while locked");

  a_break_once: assert property ( // R8
    CE && brk_hold_q && RX_CHAR_DONE && RX_CHAR_ERR.brk |=> !RX_PUSH)
    else $error("second break character loaded");

  a_presc_period: assert property ( // R3
    s_presc_tick ##1 (CE && mcr_q[MCR_PRESC] && !wr_mcr) [*3]
      |=> BRG_TICK)
    else $error("divide by four tick missing");

  a_imm_report: assert property ( // R9
    CE && LS_INT_EN && xfr_q[XFR_LSIMM] && push && (|RX_CHAR_ERR)
      |=> imm_q ##1 (!$past(CE) || !$past(LS_INT_EN) ||
                     ($past(mcr_q[MCR_INTOS]) ? IRQ_OE : IRQ_O)))
    else $error("immediate bad character not reported");

  a_half_duplex: assert property ( // R13
    CE && mcr_q[MCR_IR] && xfr_q[XFR_HDX] && TX_BUSY |=> RX_DATA)
    else $error("receiver not muted while sending");

  a_mcr_lock: assert property ( // R20
    CE && wr_mcr && !ENH_UNLOCK |=>
      (mcr_q & MCR_ENH_MASK) == ($past(mcr_q) & MCR_ENH_MASK))
    else $error("locked control bits changed");

  a_ce_freeze: assert property ( // R20
    !CE |=> $stable(mcr_q) && $stable(xfr_q) && $stable(err_cnt_q))
    else $error("state changed while clock enable low");
endmodule // uart_status_ctrl
`default_nettype wire

/* hw/uart_stat_pkg.sv */
// Constants and types for the serial port status and feature block
// What this block does
// [R1] Interrupt pin driven or open-source per mode
// [R2] Infrared mode routes serial paths through codec
// [R3] Prescaler passes clock direct or divided four
// [R4] Data ready tracks held receive characters
// [R5] Full-FIFO arrival sets overrun, drops character
// [R6] Parity flag belongs to read-position character
// [R7] Framing flag belongs to read-position character
// [R8] Break flagged once, cleared by status read
// [R9] Bad-character interrupt timing select
// [R10] Holding empty follows transmit FIFO contents
// [R11] Transmitter empty needs FIFO and shifter empty
// [R12] FIFO error summary while flagged characters remain
// [R13] Half-duplex infrared mutes receiver while sending
// [R14] Infrared receive input optionally inverted
// [R15] Auto RS-485 drives direction on RTS
// [R16] RS-485 direction polarity select
// [R17] Xon-any resumes transmit on any character
// [R18] Modem change flags set on input change
// [R19] Ring change flag only on rising edge
// [R20] Enhanced bits writable only while unlocked
// [R21] Status reads clear error and change flags
// [R22] Reserved feature bits ignored on write
package uart_stat_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFF_MCR = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_LSR = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_XFR = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_MSR = 3'h3;

  localparam int unsigned MCR_RTS   = 1;
  localparam int unsigned MCR_INTOS = 5;
  localparam int unsigned MCR_IR    = 6;
  localparam int unsigned MCR_PRESC = 7;
  localparam logic [7:0]  MCR_ENH_MASK = 8'hE0;
  localparam logic [7:0]  MCR_RST = 8'h00;

  localparam int unsigned XFR_HDX   = 0;
  localparam int unsigned XFR_IRINV = 1;
  localparam int unsigned XFR_485   = 2;
  localparam int unsigned XFR_LSIMM = 3;
  localparam int unsigned XFR_XANY  = 4;
  localparam int unsigned XFR_485INV = 5;
  localparam int unsigned XFR_W     = 6;
  localparam logic [XFR_W-1:0] XFR_RST = 6'h00;

  localparam int unsigned LSR_THRE = 5;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [4:0] PIN_IDLE = 5'h1F;

  typedef struct packed {
    logic brk;
    logic ferr;
    logic perr;
  } rx_err_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_t;
endpackage

/* dv/uart_far_model.sv */
// Far-side line and modem equipment driving the receive and modem pins
`timescale 1ns/1ps
`default_nettype none
module uart_far_model
  import uart_stat_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   line_lvl,
  input  wire modem_t modem_lvl,
  output var logic    rx_pin,
  output var modem_t  modem_n
);
  // Pins idle high until told otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_pin  <= 1'h1;
      modem_n <= 4'hF;
    end else begin
      rx_pin  <= line_lvl;
      modem_n <= modem_lvl;
    end
  end
endmodule // uart_far_model
`default_nettype wire

/* dv/uart_status_ctrl_bench.sv */
// Self-checking bench for the status and feature block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module uart_status_ctrl_bench
  import uart_stat_pkg::*;
;
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, unlock = 1, ls_en = 0;
  logic ms_en = 0, sw_flow = 0, done = 0, full = 0, hvalid = 0, pop = 0;
  logic hold_e = 1, shift_e = 1, busy = 0, txd = 1, ir_tx = 0, ir_rx = 0;
  logic line_lvl = 1, rx_pin, push, tx_pin, rx_data, ir_in, rts_n;
  logic irq_o, irq_oe, brg_tick, xon, ce = 1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  rx_err_t cerr = 3'h0, herr = 3'h0;
  modem_t mdm = 4'hF, modem_n;
  logic [15:0] ticks = 16'h0000, t0;
  int num_errors = 0, checked = 0, cycles = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) ticks <= ticks + {15'h0000, brg_tick};

  uart_far_model far (.clk(clk), .rst(rst), .line_lvl(line_lvl),
    .modem_lvl(mdm), .rx_pin(rx_pin), .modem_n(modem_n));

  uart_status_ctrl dut (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .ENH_UNLOCK(unlock),
    .LS_INT_EN(ls_en), .MS_INT_EN(ms_en), .SW_FLOW_ON(sw_flow),
    .RX_CHAR_DONE(done), .RX_CHAR_ERR(cerr), .RX_FIFO_FULL(full),
    .RX_HEAD_VALID(hvalid), .RX_HEAD_ERR(herr), .RX_POP(pop), .RX_PUSH(push),
    .TX_HOLD_EMPTY(hold_e), .TX_SHIFT_EMPTY(shift_e), .TX_BUSY(busy),
    .TXD(txd), .IR_ENC_TX(ir_tx), .IR_DEC_RX(ir_rx), .RX_PIN(rx_pin),
    .MODEM_N(modem_n), .TX_PIN(tx_pin), .RX_DATA(rx_data),
    .IR_DEC_IN(ir_in), .RTS_N(rts_n), .IRQ_O(irq_o), .IRQ_OE(irq_oe),
    .BRG_TICK(brg_tick), .XON_RESUME(xon));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr_s <= 0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1; addr <= a;
    @(posedge clk);
    rd_s <= 0;
    #1 `CHK(rdata, e)
  endtask
  // Character completes; push is visible right after the sampling edge
  task automatic rx_char(input logic [2:0] e, input logic exp_push);
    @(posedge clk);
    done <= 1; cerr <= e;
    @(posedge clk);
    done <= 0;
    #1 `CHK(push, exp_push)
  endtask
  task automatic pop_head();
    @(posedge clk);
    pop <= 1;
    @(posedge clk);
    pop <= 0; hvalid <= 0; herr <= 3'h0;
    cyc(3);
  endtask

  task automatic t_reset();
    rdc(OFF_MCR, 8'h00);
    rdc(OFF_XFR, 8'h00);
    rdc(OFF_LSR, 8'h60);
    rdc(OFF_MSR, 8'h00);
    rdc(3'h5, 8'h00);
    `CHK(irq_oe, 1'h1)
    `CHK(irq_o, 1'h0)
  endtask
  task automatic t_lock();
    unlock <= 0;
    wr(OFF_MCR, 8'hFF);
    wr(OFF_XFR, 8'h04);
    rdc(OFF_MCR, 8'h1F);
    busy <= 1; hold_e <= 0; shift_e <= 0;
    cyc(3);
    `CHK(rts_n, 1'h0)
    rdc(OFF_LSR, 8'h00);
    hold_e <= 1;
    rdc(OFF_LSR, 8'h20);
    unlock <= 1;
    wr(OFF_MCR, 8'h00);
  endtask
  task automatic t_485();
    wr(OFF_XFR, 8'h04);
    cyc(3);
    `CHK(rts_n, 1'h1)
    busy <= 0; shift_e <= 1;
    cyc(3);
    `CHK(rts_n, 1'h0)
    wr(OFF_XFR, 8'h24);
    cyc(3);
    `CHK(rts_n, 1'h1)
    busy <= 1; shift_e <= 0;
    cyc(3);
    `CHK(rts_n, 1'h0)
    wr(OFF_XFR, 8'hC0);
    cyc(3);
    `CHK(rts_n, 1'h1)
    busy <= 0; shift_e <= 1;
  endtask
  task automatic t_presc();
    t0 = ticks;
    cyc(400);
    `CHK(ticks - t0, 16'h0190)
    wr(OFF_MCR, 8'h80);
    cyc(8);
    t0 = ticks;
    cyc(400);
    `CHK(ticks - t0, 16'h0064)
    wr(OFF_MCR, 8'h00);
  endtask
  task automatic t_ir();
    txd <= 0;
    cyc(3);
    `CHK(tx_pin, 1'h0)
    wr(OFF_MCR, 8'h40);
    ir_tx <= 1;
    cyc(8);
    `CHK(tx_pin, 1'h1)
    `CHK(ir_in, 1'h1)
    `CHK(rx_data, 1'h0)
    wr(OFF_XFR, 8'h02);
    cyc(8);
    `CHK(ir_in, 1'h0)
    wr(OFF_XFR, 8'h01);
    busy <= 1;
    cyc(3);
    `CHK(rx_data, 1'h1)
    busy <= 0; txd <= 1; ir_tx <= 0;
    wr(OFF_XFR, 8'h00);
    wr(OFF_MCR, 8'h00);
  endtask
  task automatic t_modem();
    ms_en <= 1; mdm <= 4'hE;
    cyc(8);
    `CHK(irq_o, 1'h1)
    rdc(OFF_MSR, 8'h11);
    rdc(OFF_MSR, 8'h10);
    `CHK(irq_o, 1'h0)
    mdm <= 4'hA;
    cyc(8);
    rdc(OFF_MSR, 8'h50);
    mdm <= 4'hE;
    cyc(8);
    rdc(OFF_MSR, 8'h14);
    wr(OFF_MCR, 8'h20);
    mdm <= 4'hF;
    cyc(8);
    `CHK({irq_o, irq_oe}, 2'h3)
    rdc(OFF_MSR, 8'h01);
    cyc(2);
    `CHK({irq_o, irq_oe}, 2'h2)
    wr(OFF_MCR, 8'h00);
    ms_en <= 0;
  endtask
  task automatic t_rx();
    ls_en <= 1; full <= 1;
    rx_char(3'h0, 1'h0);
    cyc(1);
    `CHK(irq_o, 1'h1)
    rdc(OFF_LSR, 8'h62);
    rdc(OFF_LSR, 8'h60);
    full <= 0;
    rx_char(3'h1, 1'h1);
    cyc(2);
    `CHK(irq_o, 1'h0)
    rdc(OFF_LSR, 8'hE0);
    hvalid <= 1; herr <= 3'h1;
    cyc(3);
    `CHK(irq_o, 1'h1)
    rdc(OFF_LSR, 8'hE5);
    pop_head();
    rdc(OFF_LSR, 8'h60);
    wr(OFF_XFR, 8'h08);
    rx_char(3'h2, 1'h1);
    cyc(2);
    `CHK(irq_o, 1'h1)
    rdc(OFF_LSR, 8'hE0);
    cyc(2);
    `CHK(irq_o, 1'h0)
    hvalid <= 1; herr <= 3'h2;
    cyc(3);
    `CHK(irq_o, 1'h1)
    rdc(OFF_LSR, 8'hE9);
    pop_head();
    wr(OFF_XFR, 8'h00);
    line_lvl <= 0;
    cyc(8);
    rx_char(3'h4, 1'h1);
    rx_char(3'h4, 1'h0);
    line_lvl <= 1;
    hvalid <= 1; herr <= 3'h4;
    cyc(8);
    rdc(OFF_LSR, 8'hF1);
    pop_head();
    rdc(OFF_LSR, 8'h60);
    ls_en <= 0;
  endtask
  task automatic t_xon();
    sw_flow <= 1;
    rx_char(3'h0, 1'h1);
    `CHK(xon, 1'h0)
    wr(OFF_XFR, 8'h10);
    rx_char(3'h0, 1'h1);
    `CHK(xon, 1'h1)
    cyc(1);
    `CHK(xon, 1'h0)
    sw_flow <= 0;
    wr(OFF_XFR, 8'h00);
  endtask
  // Clock enable low: write and overrun both refused
  task automatic t_ce();
    ce <= 0; full <= 1;
    wr(OFF_MCR, 8'h02);
    rx_char(3'h0, 1'h0);
    cyc(3);
    `CHK(rts_n, 1'h1)
    ce <= 1; full <= 0;
    rdc(OFF_MCR, 8'h00);
    rdc(OFF_LSR, 8'h60);
  endtask

  task automatic end_sim();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    cyc(2);
    t_reset();
    t_lock();
    t_485();
    t_presc();
    t_ir();
    t_modem();
    t_rx();
    t_xon();
    t_ce();
    end_sim();
  end
endmodule // uart_status_ctrl_bench
`default_nettype wire
